// ### rtl/fhc_pkg.sv
// constants and state types for the sector flash host controller
package fhc_pkg;

    // ************************************************************
    // pin geometry
    // ************************************************************
    localparam int unsigned ADDR_W       = 18;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned SECTOR_LSB   = 8;   // sector select bits 17..8
    localparam int unsigned SECTOR_W     = ADDR_W - SECTOR_LSB; // 1024 sectors
    localparam int unsigned SECTOR_BYTES = 256;
    localparam int unsigned UNLOCK_LEN   = 3;
    localparam int unsigned POLL_BIT     = 7;   // poll_status_bit
    localparam int unsigned TOGGLE_BIT   = 6;   // toggle_status_bit
    localparam int unsigned SYNC_STAGES  = 3;

    // ************************************************************
    // timing, figures in their own units, counts derived
    // ************************************************************
    localparam int unsigned CLK_FREQ_MHZ   = 100;
    localparam int unsigned STROBE_LOW_NS  = 50;   // well above 15 ns filter
    localparam int unsigned READ_ACCESS_NS = 150;
    localparam int unsigned LOAD_GAP_US    = 150;
    localparam int unsigned PROG_MAX_MS    = 20;
    localparam int unsigned POR_DELAY_MS   = 10;
    // least times round up
    localparam int unsigned STROBE_CYCLES =
        (STROBE_LOW_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int unsigned READ_CYCLES =
        (READ_ACCESS_NS * CLK_FREQ_MHZ + 999) / 1000 + SYNC_STAGES;
    // longest time rounds down
    localparam int unsigned LOAD_GAP_CYCLES = LOAD_GAP_US * CLK_FREQ_MHZ;
    localparam int unsigned PROG_MAX_CYCLES =
        PROG_MAX_MS * 1000 * CLK_FREQ_MHZ;
    localparam int unsigned POR_CYCLES = POR_DELAY_MS * 1000 * CLK_FREQ_MHZ;
    localparam int unsigned GAP_MARGIN = 8;     // setup cycles before a fall
    localparam int unsigned TMR_W      = 21;

    // ************************************************************
    // controller state
    // ************************************************************
    typedef enum logic [2:0] {
        FHC_IDLE,
        FHC_WR_SETUP,
        FHC_WR_LOW,
        FHC_WR_END,
        FHC_GAP,
        FHC_RD,
        FHC_POLL
    } fhc_state_e;

    typedef struct packed {
        fhc_state_e              state;
        logic                    cmd_prog;
        logic [ADDR_W-1:0]       addr;
        logic [SECTOR_W-1:0]     sector;
        logic [1:0]              unl;
        logic [8:0]              load_cnt;
        logic [7:0]              cnt;
        logic [TMR_W-1:0]        tmo;
        logic [TMR_W-1:0]        por;
        logic                    por_done;
        logic                    last_bit7;
        logic                    prev_bit6;
        logic                    have_prev;
        logic [1:0][DATA_W-1:0]  buf_mem;
        logic [1:0]              buf_cnt;
        logic                    buf_wp;
        logic                    buf_rp;
        logic                    ce_n;
        logic                    oe_n;
        logic                    we_n;
        logic [DATA_W-1:0]       dq_out;
        logic                    dq_oe_n;
        logic [DATA_W-1:0]       dq_s1;
        logic [DATA_W-1:0]       dq_s2;
        logic [DATA_W-1:0]       dq_s3;
        logic                    cmd_ready;
        logic                    wr_ready;
        logic                    rd_valid;
        logic [DATA_W-1:0]       rd_data;
        logic                    done;
        logic                    err;
    } fhc_state_s;

endpackage

// ### rtl/fhc_host.sv
// host controller that reads and sector-programs a parallel flash
`timescale 1ns/1ps
module fhc_host #(
    parameter logic [17:0] UNLOCK_ADDR0 = 18'h00001,
    parameter logic [7:0]  UNLOCK_DATA0 = 8'h11,
    parameter logic [17:0] UNLOCK_ADDR1 = 18'h00002,
    parameter logic [7:0]  UNLOCK_DATA1 = 8'h22,
    parameter logic [17:0] UNLOCK_ADDR2 = 18'h00003,
    parameter logic [7:0]  UNLOCK_DATA2 = 8'h33,
    parameter int unsigned LOAD_GAP_CYC = fhc_pkg::LOAD_GAP_CYCLES,
    parameter int unsigned PROG_MAX_CYC = fhc_pkg::PROG_MAX_CYCLES,
    parameter int unsigned POR_CYC      = fhc_pkg::POR_CYCLES
) (
    input  wire logic        CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        CLK_EN_IN,
    input  wire logic        CMD_VALID_IN,
    input  wire logic        CMD_PROG_IN,
    input  wire logic [17:0] CMD_ADDR_IN,
    output logic             CMD_READY_OUT,
    input  wire logic        WR_VALID_IN,
    input  wire logic [7:0]  WR_DATA_IN,
    output logic             WR_READY_OUT,
    output logic             RD_VALID_OUT,
    output logic [7:0]       RD_DATA_OUT,
    output logic             DONE_OUT,
    output logic             ERR_OUT,
    output logic [17:0]      FL_ADDR_OUT,
    output logic             FL_CE_N_OUT,
    output logic             FL_OE_N_OUT,
    output logic             FL_WE_N_OUT,
    input  wire logic [7:0]  FL_DQ_IN,
    output logic [7:0]       FL_DQ_OUT,
    output logic             FL_DQ_OE_N_OUT
);

    // ************************************************************
    // limits at counter width
    // ************************************************************
    localparam int unsigned TW = fhc_pkg::TMR_W;
    localparam logic [TW-1:0] GAP_LIM  = TW'(LOAD_GAP_CYC);
    localparam logic [TW-1:0] GAP_ABRT =
        TW'(LOAD_GAP_CYC - fhc_pkg::GAP_MARGIN);
    localparam logic [TW-1:0] PROG_LIM = TW'(PROG_MAX_CYC);
    localparam logic [TW-1:0] POR_LIM  = TW'(POR_CYC - 1);
    localparam logic [7:0] STB_CNT = 8'(fhc_pkg::STROBE_CYCLES - 1);
    localparam logic [7:0] RD_CNT  = 8'(fhc_pkg::READ_CYCLES - 1);

    fhc_pkg::fhc_state_s r;
    fhc_pkg::fhc_state_s n;

    // ************************************************************
    // bus cycle launchers
    // ************************************************************
    // write: chip select low, output enable held high, data driven
    function automatic fhc_pkg::fhc_state_s start_wr(
        input fhc_pkg::fhc_state_s s,
        input logic [17:0]          a,
        input logic [7:0]           d
    );
        fhc_pkg::fhc_state_s t;
        t         = s;
        t.addr    = a;
        t.dq_out  = d;
        t.dq_oe_n = 1'b0;
        t.ce_n    = 1'b0;
        t.oe_n    = 1'b1;
        t.state   = fhc_pkg::FHC_WR_SETUP;
        return t;
    endfunction

    // read: bus released first so device and host never fight
    function automatic fhc_pkg::fhc_state_s start_rd(
        input fhc_pkg::fhc_state_s s,
        input logic [17:0]          a
    );
        fhc_pkg::fhc_state_s t;
        t         = s;
        t.addr    = a;
        t.dq_oe_n = 1'b1;
        t.ce_n    = 1'b0;
        t.oe_n    = 1'b0;
        t.cnt     = RD_CNT;
        t.state   = fhc_pkg::FHC_RD;
        return t;
    endfunction

    // ************************************************************
    // next state
    // ************************************************************
    always_comb
    begin
        logic             push;
        logic             pop;
        logic             fin;
        logic [17:0]      ua;
        logic [7:0]       ud;
        logic [7:0]       pb;
        push = WR_VALID_IN & r.wr_ready;
        pop  = 1'b0;
        fin  = 1'b0;
        pb   = r.buf_mem[r.buf_rp];
        n    = r;
        n.rd_valid = 1'b0;
        n.done     = 1'b0;
        n.err      = 1'b0;
        // three stage pin synchroniser on the data bus
        n.dq_s1 = FL_DQ_IN;
        n.dq_s2 = r.dq_s1;
        n.dq_s3 = r.dq_s2;
        // power-on lockout: no command, read or program, accepted for the delay
        if (!r.por_done)
        begin
            if (r.por == POR_LIM)
                n.por_done = 1'b1;
            else
                n.por = r.por + {{(TW-1){1'b0}}, 1'b1};
        end
        if (r.tmo != {TW{1'b1}})
            n.tmo = r.tmo + {{(TW-1){1'b0}}, 1'b1};
        // unlock command of the current step, issued in order
        ua = (r.unl == 2'd0) ? UNLOCK_ADDR0 :
             (r.unl == 2'd1) ? UNLOCK_ADDR1 : UNLOCK_ADDR2;
        ud = (r.unl == 2'd0) ? UNLOCK_DATA0 :
             (r.unl == 2'd1) ? UNLOCK_DATA1 : UNLOCK_DATA2;

        unique case (r.state)
            fhc_pkg::FHC_IDLE:
            begin
                n.cmd_ready = r.por_done;
                if (CMD_VALID_IN && r.cmd_ready)
                begin
                    n.cmd_ready = 1'b0;
                    n.cmd_prog  = CMD_PROG_IN;
                    n.addr      = CMD_ADDR_IN;
                    // kept apart: the unlock writes overwrite the address
                    n.sector    = CMD_ADDR_IN[17:fhc_pkg::SECTOR_LSB];
                    n.unl       = 2'd0;
                    n.load_cnt  = 9'h000;
                    if (CMD_PROG_IN)
                        n = start_wr(n, UNLOCK_ADDR0, UNLOCK_DATA0);
                    else
                        n = start_rd(n, CMD_ADDR_IN);
                end
            end
            fhc_pkg::FHC_WR_SETUP:
            begin
                // address settles before the fall, taken on it
                n.we_n = 1'b0;
                n.cnt  = STB_CNT;
            end
            fhc_pkg::FHC_WR_LOW:
            begin
                // pulse stays far wider than the device noise filter
                if (r.cnt == 8'h00)
                    n.we_n = 1'b1;
                else
                    n.cnt = r.cnt - 8'h01;
            end
            fhc_pkg::FHC_WR_END:
            begin
                // data latched on the strobe rise, then release
                n.ce_n    = 1'b1;
                n.dq_oe_n = 1'b1;
                n.tmo     = {TW{1'b0}};
                if (r.unl != 2'd3)
                    n.unl = r.unl + 2'd1;
            end
            fhc_pkg::FHC_GAP:
            begin
                if (r.unl != 2'd3)
                    n = start_wr(n, ua, ud);
                else if (r.load_cnt[8])
                begin
                    // wait out the load window before the first poll
                    n.have_prev = 1'b0;
                    if (r.tmo >= GAP_LIM)
                    begin
                        n.tmo = {TW{1'b0}};
                        n = start_rd(n, r.addr);
                    end
                end
                else if (r.buf_cnt != 2'd0)
                begin
                    // sequential offsets; any order would do
                    pop         = 1'b1;
                    n.last_bit7 = pb[fhc_pkg::POLL_BIT];
                    n.load_cnt  = r.load_cnt + 9'h001;
                    n = start_wr(n, {r.sector,
                                     r.load_cnt[7:0]}, pb);
                end
                else if (r.tmo >= GAP_ABRT)
                begin
                    // source starved: device will program a partial sector
                    n.err   = 1'b1;
                    n.state = fhc_pkg::FHC_IDLE;
                end
            end
            fhc_pkg::FHC_RD:
            begin
                // a change counts once the last two sync stages agree
                if (r.cnt != 8'h00)
                    n.cnt = r.cnt - 8'h01;
                else if (r.dq_s2 == r.dq_s3)
                begin
                    n.ce_n = 1'b1;
                    n.oe_n = 1'b1;
                    if (!r.cmd_prog)
                    begin
                        n.rd_data  = r.dq_s3;
                        n.rd_valid = 1'b1;
                        n.state    = fhc_pkg::FHC_IDLE;
                    end
                    else
                    begin
                        // true bit 7 and bit 6 steady mean the cycle ended
                        fin = (r.dq_s3[fhc_pkg::POLL_BIT] == r.last_bit7) &&
                              r.have_prev &&
                              (r.dq_s3[fhc_pkg::TOGGLE_BIT] == r.prev_bit6);
                        n.prev_bit6 = r.dq_s3[fhc_pkg::TOGGLE_BIT];
                        n.have_prev = 1'b1;
                        if (fin)
                        begin
                            n.done  = 1'b1;
                            n.state = fhc_pkg::FHC_IDLE;
                        end
                        else if (r.tmo >= PROG_LIM)
                        begin
                            n.err   = 1'b1;
                            n.state = fhc_pkg::FHC_IDLE;
                        end
                        else
                            n.state = fhc_pkg::FHC_POLL;
                    end
                end
            end
            fhc_pkg::FHC_POLL:
                // one cycle with output enable high splits successive reads
                n = start_rd(n, r.addr);
        endcase
        if (r.state == fhc_pkg::FHC_WR_LOW && r.cnt == 8'h00)
            n.state = fhc_pkg::FHC_WR_END;
        else if (r.state == fhc_pkg::FHC_WR_SETUP)
            n.state = fhc_pkg::FHC_WR_LOW;
        else if (r.state == fhc_pkg::FHC_WR_END)
            n.state = fhc_pkg::FHC_GAP;

        // two-entry buffer: ready drops at two so no word is lost
        if (push)
        begin
            n.buf_mem[r.buf_wp] = WR_DATA_IN;
            n.buf_wp = ~r.buf_wp;
        end
        if (pop)
            n.buf_rp = ~r.buf_rp;
        n.buf_cnt  = r.buf_cnt + {1'b0, push} - {1'b0, pop};
        n.wr_ready = (n.buf_cnt != 2'd2);
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
        begin
            r           <= '0;
            r.state     <= fhc_pkg::FHC_IDLE;
            r.ce_n      <= 1'b1;
            r.oe_n      <= 1'b1;
            r.we_n      <= 1'b1;
            r.dq_oe_n   <= 1'b1;
            r.wr_ready  <= 1'b1;
        end
        else if (CLK_EN_IN)
            r <= n;
    end

    // outputs straight from the state register
    assign CMD_READY_OUT  = r.cmd_ready;
    assign WR_READY_OUT   = r.wr_ready;
    assign RD_VALID_OUT   = r.rd_valid;
    assign RD_DATA_OUT    = r.rd_data;
    assign DONE_OUT       = r.done;
    assign ERR_OUT        = r.err;
    assign FL_ADDR_OUT    = r.addr;
    assign FL_CE_N_OUT    = r.ce_n;
    assign FL_OE_N_OUT    = r.oe_n;
    assign FL_WE_N_OUT    = r.we_n;
    assign FL_DQ_OUT      = r.dq_out;
    assign FL_DQ_OE_N_OUT = r.dq_oe_n;

endmodule // fhc_host

// ### verification/fhc_chk.sv
// concurrent checks on the pins of the flash host controller
`timescale 1ns/1ps
module fhc_chk #(
    parameter int unsigned POR_CYC = 10
) (
    input wire logic        CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic        CLK_EN_IN,
    input wire logic        CMD_READY_OUT,
    input wire logic        RD_VALID_OUT,
    input wire logic        DONE_OUT,
    input wire logic        ERR_OUT,
    input wire logic [17:0] FL_ADDR_OUT,
    input wire logic        FL_CE_N_OUT,
    input wire logic        FL_OE_N_OUT,
    input wire logic        FL_WE_N_OUT,
    input wire logic [7:0]  FL_DQ_OUT,
    input wire logic        FL_DQ_OE_N_OUT
);
    // ********
    // checks
    // ********
    logic [31:0] por_cnt_reg;
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // enabled edges since reset; saturates so it never wraps back
    always_ff @(posedge CLK_IN)
    begin
        if (!RST_N_IN)
            por_cnt_reg <= 32'h0000_0000;
        else if (CLK_EN_IN && por_cnt_reg != 32'hffff_ffff)
            por_cnt_reg <= por_cnt_reg + 32'h0000_0001;
    end
    AST_WE_FRAME: assert property (!FL_WE_N_OUT |->
        !FL_CE_N_OUT && FL_OE_N_OUT) else $error("strobe outside write frame");
    AST_WE_DRIVES: assert property (!FL_WE_N_OUT |->
        !FL_DQ_OE_N_OUT) else $error("data not driven during strobe");
    AST_READ_SAFE: assert property (!FL_OE_N_OUT |->
        FL_DQ_OE_N_OUT && FL_WE_N_OUT) else $error("bus contention on read");
    AST_WE_WIDTH: assert property ($fell(FL_WE_N_OUT) |->
        !FL_WE_N_OUT[*5] ##1 FL_WE_N_OUT) else $error("strobe width wrong");
    AST_LOAD_STABLE: assert property (!FL_WE_N_OUT |->
        $stable(FL_ADDR_OUT) && $stable(FL_DQ_OUT))
        else $error("address or data moved under strobe");
    AST_LOCKOUT: assert property (CMD_READY_OUT |->
        por_cnt_reg >= POR_CYC) else $error("ready inside lockout");
    AST_DONE_PULSE: assert property (DONE_OUT |->
        !ERR_OUT ##1 !DONE_OUT) else $error("done pulse malformed");
    AST_READ_HELD: assert property ($fell(FL_OE_N_OUT) |=>
        (!FL_CE_N_OUT && !FL_OE_N_OUT && $stable(FL_ADDR_OUT))[*8])
        else $error("read cycle cut short");
    AST_RD_THEN_READY: assert property (RD_VALID_OUT |=>
        !RD_VALID_OUT ##[0:2] CMD_READY_OUT) else $error("no ready after read");
endmodule // fhc_chk
bind fhc_host fhc_chk #(.POR_CYC(POR_CYC)) u_fhc_chk (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .CLK_EN_IN(CLK_EN_IN),
    .CMD_READY_OUT(CMD_READY_OUT), .RD_VALID_OUT(RD_VALID_OUT),
    .DONE_OUT(DONE_OUT), .ERR_OUT(ERR_OUT), .FL_ADDR_OUT(FL_ADDR_OUT),
    .FL_CE_N_OUT(FL_CE_N_OUT), .FL_OE_N_OUT(FL_OE_N_OUT),
    .FL_WE_N_OUT(FL_WE_N_OUT), .FL_DQ_OUT(FL_DQ_OUT),
    .FL_DQ_OE_N_OUT(FL_DQ_OE_N_OUT)
);

// ### verification/fhc_flash_model.sv
// behavioural parallel flash device on the far side of the controller
`timescale 1ns/1ps
module fhc_flash_model #(
    parameter logic [2:0][17:0] UNL_A   = {18'h00003, 18'h00002, 18'h00001},
    parameter logic [2:0][7:0]  UNL_D   = {8'h33, 8'h22, 8'h11},
    parameter int               GAP_NS  = 1900,
    parameter int               PROG_NS = 2000,
    parameter int               SLOW_NS = 30000,
    parameter logic [7:0]       ID_MFR  = 8'h5a, // arbitrary value
    parameter logic [7:0]       ID_DEV  = 8'ha5  // arbitrary value
) (
    input  wire logic [17:0] addr_in,
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic [7:0]  dq_in,
    input  wire logic        slow_in,
    input  wire logic        stuck_in,
    input  wire logic        id_in,
    output logic [7:0]       dq_out
);
    // ********
    // device
    // ********
    logic [7:0]  mem [0:262143];
    logic [7:0]  page [0:255] = '{default: 8'hff}; // erased look
    logic [17:0] a_lat;
    logic [7:0]  last_d, last_q;
    logic [9:0]  sec;
    logic        busy = 0, tog = 0, ok = 0, loading = 0, por_ok = 0;
    int          unl = 0; // no supply input, so lockout state persists
    int          gap_id = 0;
    wire         wr = !ce_n_in && !we_n_in && oe_n_in;
    wire         rd = !ce_n_in && !oe_n_in && we_n_in;
    // identification stands in for both entry methods: one set of codes
    wire [7:0]   rdata = id_in ? (addr_in[0] ? ID_DEV : ID_MFR)
                       : busy ? {~last_d[7], tog, last_d[5:0]}
                              : mem[addr_in];
    // a released bus shows the inverse, so stale data never passes
    assign dq_out = rd ? rdata : ~last_q;
    always @* if (rd) last_q = rdata;
    initial #100 por_ok = 1;
    // address on the later fall; pulses under 15 ns are ignored
    always @(posedge wr)
    begin
        a_lat = addr_in;
        #15 ok = wr;
    end
    // data on the earlier rise
    always @(negedge wr)
    begin
        if (ok && por_ok && !busy) take(a_lat, dq_in);
        ok = 0;
    end
    always @(negedge rd) if (busy) tog = ~tog;
    task automatic take(input logic [17:0] a, input logic [7:0] d);
        if (unl < 3 && a == UNL_A[unl] && d == UNL_D[unl]) unl++;
        else if (unl < 3)
        begin
            // stray write: timers run, array untouched
            unl = 0;
            last_d = d;
            busy = 1;
            busy <= #(PROG_NS) 1'b0;
        end
        else
        begin
            if (!loading) sec = a[17:8];
            loading = 1;
            page[a[7:0]] = d; // any order
            last_d = d;
            gap_id++;
            fork gap_wait(gap_id); join_none
        end
    endtask
    task automatic gap_wait(input int id);
        #(GAP_NS);
        if (id != gap_id) return;
        busy = 1; // quiet window over, program starts
        #(slow_in ? SLOW_NS : PROG_NS); // well inside 20 ms
        wait (!stuck_in);
        for (int i = 0; i < 256; i++) mem[{sec, i[7:0]}] = page[i];
        page = '{default: 8'hff};
        loading = 0;
        unl = 0;
        busy = 0;
    endtask
endmodule // fhc_flash_model

// ### verification/sector_flash_bus_interface_test.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
module sector_flash_bus_interface_test;
    // ********
    // bench
    // ********
    logic        clk = 0, rst_n = 0, clk_en = 1, slow = 0, stuck = 0, id = 0;
    logic        cmd_valid = 0, cmd_prog = 0, wr_valid = 0;
    logic [17:0] cmd_addr = '0, fl_addr;
    logic [7:0]  wr_data = '0, rd_data, fl_dq_out, dev_dq;
    logic        cmd_ready, wr_ready, rd_valid, done, err;
    logic        ce_n, oe_n, we_n, dq_oe_n;
    int          err_count = 0, n_compared = 0, cyc = 0;
    wire  [7:0]  dq_wire = !dq_oe_n ? fl_dq_out : dev_dq;
    fhc_host #(.LOAD_GAP_CYC(200), .PROG_MAX_CYC(5000), .POR_CYC(10)) uut (
        .CLK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(clk_en),
        .CMD_VALID_IN(cmd_valid), .CMD_PROG_IN(cmd_prog),
        .CMD_ADDR_IN(cmd_addr), .CMD_READY_OUT(cmd_ready),
        .WR_VALID_IN(wr_valid), .WR_DATA_IN(wr_data),
        .WR_READY_OUT(wr_ready), .RD_VALID_OUT(rd_valid),
        .RD_DATA_OUT(rd_data), .DONE_OUT(done), .ERR_OUT(err),
        .FL_ADDR_OUT(fl_addr), .FL_CE_N_OUT(ce_n), .FL_OE_N_OUT(oe_n),
        .FL_WE_N_OUT(we_n), .FL_DQ_IN(dq_wire), .FL_DQ_OUT(fl_dq_out),
        .FL_DQ_OE_N_OUT(dq_oe_n));
    fhc_flash_model u_dev (.addr_in(fl_addr), .ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .dq_in(dq_wire), .slow_in(slow), .stuck_in(stuck),
        .id_in(id),
        .dq_out(dev_dq));
    initial forever #5 clk = ~clk;
    // watchdog: the whole run needs about 20k cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 50000)
        begin
            err_count++;
            complete_run();
        end
    end
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (!ok)
        begin
            err_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // request raised only once ready is seen high, then held for that one edge
    task automatic issue(input logic p, input logic [17:0] a);
        for (int i = 0; i < 300 && cmd_ready !== 1'b1; i++) tick(1);
        cmd_valid = 1;
        cmd_prog = p;
        cmd_addr = a;
        tick(1);
        cmd_valid = 0;
    endtask
    task automatic read_chk(input logic [17:0] a, input logic [7:0] exp);
        issue(0, a);
        for (int i = 0; i < 100 && rd_valid !== 1'b1; i++) tick(1);
        chk(rd_valid === 1'b1 && rd_data === exp, "read data mismatch");
    endtask
    // ready is registered: its value just after an edge is what the next
    // edge samples, while reading it on the edge itself would race
    task automatic feed(input logic [7:0] b, input int n);
        int   k;
        logic acc;
        k = 0;
        while (k < n)
        begin
            wr_valid = 1;
            wr_data = b + k[7:0];
            acc = (wr_ready === 1'b1);
            tick(1);
            if (acc) k++;
        end
        wr_valid = 0;
    endtask
    // two bytes fill the buffer before the command, so it stalls first
    task automatic prog_run(input logic [9:0] s, input logic [7:0] b,
                            input int n, input logic [1:0] exp);
        logic [1:0] ev;
        ev = 2'b00;
        fork
            feed(b, n);
            begin
                tick(4);
                chk(wr_ready === 1'b0, "buffer did not fill");
                issue(1, {s, 8'h00});
                for (int i = 0; i < 12000 && ev == 2'b00; i++)
                begin
                    tick(1);
                    ev = {err, done};
                end
            end
        join
        chk(ev === exp, "program outcome wrong");
    endtask
    task automatic s_reset();
        tick(4);
        rst_n = 1;
        chk(cmd_ready === 1'b0 && wr_ready === 1'b1, "reset outputs");
        chk({ce_n, oe_n, we_n, dq_oe_n} === 4'hf, "strobes not idle");
        clk_en = 0;
        tick(30);
        chk(cmd_ready === 1'b0, "ready while frozen");
        clk_en = 1;
        tick(15);
        chk(cmd_ready === 1'b1, "lockout never ended");
    endtask
    task automatic s_ident();
        id = 1;
        read_chk(18'h00000, u_dev.ID_MFR);
        read_chk(18'h00001, u_dev.ID_DEV);
        id = 0;
    endtask
    task automatic s_basic();
        prog_run(10'h005, 8'h30, 256, 2'b01);
        read_chk({10'h005, 8'h00}, 8'h30);
        read_chk({10'h005, 8'hff}, 8'h2f);
    endtask
    task automatic s_slow_top();
        slow = 1;
        prog_run(10'h3ff, 8'hc5, 256, 2'b01);
        slow = 0;
        read_chk({10'h3ff, 8'h80}, 8'h45);
    endtask
    task automatic s_reprogram();
        prog_run(10'h005, 8'h9a, 256, 2'b01);
        read_chk({10'h005, 8'h01}, 8'h9b);
    endtask
    task automatic s_stuck();
        stuck = 1;
        prog_run(10'h100, 8'h00, 256, 2'b10);
        stuck = 0;
        tick(400);
    endtask
    task automatic s_starve();
        prog_run(10'h101, 8'h55, 10, 2'b10);
        tick(400);
        read_chk({10'h101, 8'h03}, 8'h58);
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        s_reset();
        s_ident();
        s_basic();
        s_slow_top();
        s_reprogram();
        s_stuck();
        s_starve();
        complete_run();
    end
endmodule // sector_flash_bus_interface_test
